/* File: design/recovered_clock_defs.svh */
`ifndef RECOVERED_CLOCK_DEFS_SVH
`define RECOVERED_CLOCK_DEFS_SVH

// Management register addresses and page codes.
`define PAGE_SELECT_ADDR        5'h1f
`define PAGE_MAIN               16'h0000
`define PAGE_GENERAL_PURPOSE    16'h0010
`define RECOVERED_CLOCK_CONTROL 5'h17

// Field positions inside the recovered clock control register.
`define ENABLE_BIT              15
`define FREQ_MSB                10
`define FREQ_LSB                8
`define SQUELCH_MSB             5
`define SQUELCH_LSB             4
`define SOURCE_MSB              2
`define SOURCE_LSB              0

// Writable bits and reset value of the control register.
`define CONTROL_WRITE_MASK      16'h8737
`define CONTROL_RESET           16'h0000

// Field codes.
`define FREQ_25_MHZ             3'h0
`define FREQ_125_MHZ            3'h1
`define FREQ_31P25_MHZ          3'h2
`define SOURCE_COPPER           3'h1
`define SQUELCH_STRICT          2'h0
`define SQUELCH_RELAXED         2'h1
`define SQUELCH_LINK_ONLY       2'h2
`define SQUELCH_NONE            2'h3

`endif

/* File: design/recovered_clock_pkg.sv */
package recovered_clock_pkg;

  // Speed at which the copper link came up.
  typedef enum logic [1:0] {
    speed_10,
    speed_100,
    speed_1000,
    speed_unknown
  } link_speed_type;

  // Pass or hold state of the clock gate.
  typedef enum logic {
    gate_closed,
    gate_open
  } gate_state_type;

endpackage : recovered_clock_pkg

/* File: design/squelch_policy.sv */
`timescale 1ns/1ps
`include "recovered_clock_defs.svh"

// Decides from link state and squelch level whether the clock may pass.
module squelch_policy
  import recovered_clock_pkg::*;
(
  input  wire logic           [1:0] squelch_level,
  input  wire logic                 link_up,
  input  wire logic                 link_stable,
  input  wire link_speed_type       link_speed,
  input  wire logic                 link_master,
  input  wire logic                 eee_active,
  input  wire logic                 lpi_receiving,
  output logic                      clock_allowed
);

  logic linked;
  logic no_recovery_mode;
  logic eee_mode;

  // Link conditions shared by the squelch levels.
  always_comb begin
    linked           = link_up && link_stable;
    no_recovery_mode = (link_speed == speed_10) ||
                       ((link_speed == speed_1000) && link_master);
    eee_mode         = eee_active && ((link_speed == speed_100) ||
                       ((link_speed == speed_1000) && !link_master));
  end

  // Selection of the policy by squelch level.
  always_comb begin
    unique case (squelch_level)
      `SQUELCH_STRICT:    clock_allowed = linked && !no_recovery_mode && !eee_mode;
      `SQUELCH_RELAXED:   clock_allowed = linked && (!eee_mode || lpi_receiving);
      `SQUELCH_LINK_ONLY: clock_allowed = link_up;
      `SQUELCH_NONE:      clock_allowed = 1'b1;
    endcase
  end

endmodule : squelch_policy

/* File: design/recovered_clock_output_control.sv */
// How it works
// - The recovered clock output is driven only while the enable bit is one, which resets to zero.
// - The frequency field picks 25, 125 or 31.25 MHz and reserved codes give no clock.
// - Squelch level 00 holds the output low when unlinked, unstable, 1000 Mb master or 10 Mb, or in EEE at 100 or 1000 Mb.
// - Squelch level 01 also passes the clock for master, 10 Mb and EEE while idle is received.
// - Squelch level 10 holds the output low only while the link is down.
// - Squelch level 11 never holds the output low.
// - A high external squelch input forces the output low over every register setting.
// - Only source code 001 routes the copper recovered clock; other codes give no clock.
// - Control bits survive a software reset and are cleared only by the hardware reset.
`timescale 1ns/1ps
`include "recovered_clock_defs.svh"

module recovered_clock_output_control
  import recovered_clock_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst_b,
  input  wire logic           soft_reset,
  input  wire logic    [4:0]  mgmt_addr,
  input  wire logic    [15:0] mgmt_write_data,
  input  wire logic           mgmt_write,
  input  wire logic           mgmt_read,
  output logic         [15:0] mgmt_read_data,
  input  wire logic           recovered_clock_25,
  input  wire logic           recovered_clock_125,
  input  wire logic           recovered_clock_31p25,
  input  wire logic           link_up,
  input  wire logic           link_stable,
  input  wire link_speed_type link_speed,
  input  wire logic           link_master,
  input  wire logic           eee_active,
  input  wire logic           lpi_receiving,
  input  wire logic           clock_squelch_in,
  output logic                recovered_clock_output
);

  // Register state, next values and the decoded views of the control fields.
  logic           [15:0] page_reg;
  logic           [15:0] page_next;
  logic           [15:0] control_reg;
  logic           [15:0] control_next;
  logic           [15:0] read_next;
  logic                  page_write;
  logic                  control_write;
  logic                  enable_bit;
  logic           [2:0]  freq_code;
  logic           [1:0]  squelch_code;
  logic           [2:0]  source_code;
  logic                  selected_clock;
  logic                  source_valid;
  logic                  clock_allowed;
  logic                  gate_want;
  gate_state_type        gate_reg;
  gate_state_type        gate_next;
  logic                  output_next;

  // True when an address hits the control register on the current page.
  // Both address and page must match, so the main page never reaches the control bits.
  function automatic logic control_hit(input logic [4:0] addr, input logic [15:0] page);
    control_hit = (addr == `RECOVERED_CLOCK_CONTROL) && (page == `PAGE_GENERAL_PURPOSE);
  endfunction : control_hit

  // True when an address hits the page select register.
  // The page register answers on every page, so software can always find its way back.
  function automatic logic page_hit(input logic [4:0] addr);
    page_hit = (addr == `PAGE_SELECT_ADDR);
  endfunction : page_hit

  // Write strobes for the two registers, decoded once from address and page.
  always_comb begin
    page_write    = mgmt_write && page_hit(mgmt_addr);
    control_write = mgmt_write && control_hit(mgmt_addr, page_reg);
  end

  // Next page select value; a software reset wins over a write in the same cycle,
  // so software always finds itself back on the main page after a reset.
  always_comb begin
    page_next = page_reg;
    if (soft_reset) begin
      page_next = `PAGE_MAIN;
    end else if (page_write) begin
      page_next = mgmt_write_data;
    end
  end

  // Page select register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      page_reg <= `PAGE_MAIN;
    end else begin
      page_reg <= page_next;
    end
  end

  // Next value of the control register; only writable bits change.
  // Read-only bits are masked off on write, so they always read back as zero.
  always_comb begin
    control_next = control_reg;
    if (control_write) begin
      control_next = mgmt_write_data & `CONTROL_WRITE_MASK;
    end
  end

  // Control register, cleared only by the hardware reset.
  // A software reset is ignored here on purpose, so a running clock is not disturbed.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= `CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // Read data for the page register and the control register; others read zero.
  // Decoding uses the page value before any write in the same cycle.
  always_comb begin
    read_next = 16'h0000;
    if (page_hit(mgmt_addr)) begin
      read_next = page_reg;
    end else if (control_hit(mgmt_addr, page_reg)) begin
      read_next = control_reg;
    end
  end

  // Read data is registered one cycle after the read strobe and held.
  // Holding the last value lets software sample it at leisure after the strobe.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_read_data <= 16'h0000;
    end else if (mgmt_read) begin
      mgmt_read_data <= read_next;
    end
  end

  // Control fields split out once so that every consumer reads the same slices.
  always_comb begin
    enable_bit   = control_reg[`ENABLE_BIT];
    freq_code    = control_reg[`FREQ_MSB:`FREQ_LSB];
    squelch_code = control_reg[`SQUELCH_MSB:`SQUELCH_LSB];
    source_code  = control_reg[`SOURCE_MSB:`SOURCE_LSB];
  end

  // Clock source and frequency selection.
  // Reserved rates select a constant low, so the gate can never pass them.
  // The clock inputs are sampled levels, so only rates well below the system clock
  // come through with their true shape.
  always_comb begin
    source_valid = (source_code == `SOURCE_COPPER);
    unique case (freq_code)
      `FREQ_25_MHZ:    selected_clock = recovered_clock_25;
      `FREQ_125_MHZ:   selected_clock = recovered_clock_125;
      `FREQ_31P25_MHZ: selected_clock = recovered_clock_31p25;
      default:         selected_clock = 1'b0;
    endcase
  end

  // Squelch policy for the selected level.
  // The level table lives in its own module so that it can be read in one place.
  squelch_policy policy (
    .squelch_level (squelch_code),
    .link_up       (link_up),
    .link_stable   (link_stable),
    .link_speed    (link_speed),
    .link_master   (link_master),
    .eee_active    (eee_active),
    .lpi_receiving (lpi_receiving),
    .clock_allowed (clock_allowed)
  );

  // Combined pass condition of every control.
  // Every condition is a level, so any one of them going away closes the gate.
  always_comb begin
    gate_want = enable_bit && source_valid && clock_allowed && !clock_squelch_in;
  end

  // Next gate state. Closing is immediate so that the squelch pin and a cleared enable
  // take hold within one cycle; opening waits for a low phase of the selected clock so
  // that the first pulse leaving the block is always a whole one.
  always_comb begin
    gate_next = gate_reg;
    if (!gate_want) begin
      gate_next = gate_closed;
    end else if (!selected_clock) begin
      gate_next = gate_open;
    end
  end

  // Gate state register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gate_reg <= gate_closed;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // Next output level; the pass condition is repeated here so that a squelch or a
  // disable drops the output on the very next edge, without waiting for the gate.
  always_comb begin
    output_next = (gate_reg == gate_open) && gate_want && selected_clock;
  end

  // Registered clock output, so the pin never carries a combinational glitch.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      recovered_clock_output <= 1'b0;
    end else begin
      recovered_clock_output <= output_next;
    end
  end

endmodule : recovered_clock_output_control

/* File: tb/recovered_clock_output_control_chk.sv */
`timescale 1ns/1ps
module recovered_clock_chk
  import recovered_clock_pkg::*;
(
  input wire logic           clock,
  input wire logic           rst_b,
  input wire logic           soft_reset,
  input wire logic    [4:0]  mgmt_addr,
  input wire logic    [15:0] mgmt_write_data,
  input wire logic           mgmt_write,
  input wire logic           recovered_clock_25,
  input wire logic           link_up,
  input wire logic           link_stable,
  input wire link_speed_type link_speed,
  input wire logic           clock_squelch_in,
  input wire logic           recovered_clock_output
);
  logic [15:0] page_reg, ctl_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Shadow copy of the page and control registers, rebuilt from bus writes.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      page_reg <= 16'h0000;
      ctl_reg  <= 16'h0000;
    end else begin
      if (soft_reset) page_reg <= 16'h0000;
      else if (mgmt_write && mgmt_addr == 5'h1f) page_reg <= mgmt_write_data;
      if (mgmt_write && mgmt_addr == 5'h17 && page_reg == 16'h0010)
        ctl_reg <= mgmt_write_data & 16'h8737;
    end
  end
  property p_enable; !ctl_reg[15] |=> !recovered_clock_output; endproperty
  a_enable: assert property (p_enable) else $error("clock while disabled");
  property p_freq; ctl_reg[10:8] > 3'h2 |=> !recovered_clock_output; endproperty
  a_freq: assert property (p_freq) else $error("clock on reserved rate");
  property p_strict; ctl_reg[5:4] == 2'h0 && (link_speed == speed_10 || !link_stable)
    |=> !recovered_clock_output; endproperty
  a_strict: assert property (p_strict) else $error("level zero leak");
  property p_relaxed; ctl_reg[5:4] == 2'h1 && !link_up |=> !recovered_clock_output; endproperty
  a_relaxed: assert property (p_relaxed) else $error("level one leak");
  property p_link; ctl_reg[5:4] == 2'h2 && !link_up |=> !recovered_clock_output; endproperty
  a_link: assert property (p_link) else $error("level two leak");
  property p_free; (ctl_reg == 16'h8031 && !clock_squelch_in) [*4]
    |=> recovered_clock_output == $past(recovered_clock_25); endproperty
  a_free: assert property (p_free) else $error("level three not passing");
  property p_pin; clock_squelch_in |=> !recovered_clock_output; endproperty
  a_pin: assert property (p_pin) else $error("pin squelch ignored");
  property p_source; ctl_reg[2:0] != 3'h1 |=> !recovered_clock_output; endproperty
  a_source: assert property (p_source) else $error("clock from bad source");
  property p_glitch; ((ctl_reg[10:8] == 3'h0) [*3] ##0 $rose(recovered_clock_output))
    |-> $past(ctl_reg[15]) && !$past(recovered_clock_25, 2); endproperty
  a_glitch: assert property (p_glitch) else $error("gate opened while off");
  c_active: cover property ($rose(recovered_clock_output));
  c_pin: cover property (clock_squelch_in && ctl_reg[15]);
  c_soft: cover property (soft_reset && ctl_reg[15]);
endmodule : recovered_clock_chk

bind recovered_clock_output_control recovered_clock_chk i_chk (.clock, .rst_b, .soft_reset,
  .mgmt_addr, .mgmt_write_data, .mgmt_write, .recovered_clock_25, .link_up, .link_stable,
  .link_speed, .clock_squelch_in, .recovered_clock_output);

/* File: tb/timing_sink_model.sv */
`timescale 1ns/1ps
module timing_sink_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        recovered_clock_output,
  input  wire logic        squelch_request,
  output logic             clock_squelch_in,
  output logic      [15:0] edge_count
);
  logic last_level;
  assign clock_squelch_in = squelch_request;
  // Counts rising edges of the received clock.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_level <= 1'b0;
      edge_count <= 16'h0000;
    end else begin
      last_level <= recovered_clock_output;
      if (recovered_clock_output && !last_level) edge_count <= edge_count + 16'h0001;
    end
  end
endmodule : timing_sink_model

/* File: tb/recovered_clock_output_control_bench.sv */
`timescale 1ns/1ps
module recovered_clock_output_control_bench;
  import recovered_clock_pkg::*;
  logic           clock, rst_b, soft_reset, mgmt_write, mgmt_read, squelch_request;
  logic           recovered_clock_25, recovered_clock_125, recovered_clock_31p25;
  logic           link_up, link_stable, link_master, eee_active, lpi_receiving;
  logic           clock_squelch_in, recovered_clock_output;
  logic    [4:0]  mgmt_addr;
  logic    [15:0] mgmt_write_data, mgmt_read_data, edge_count, start;
  link_speed_type link_speed;
  int             err_count, total_checks, cycles;
  recovered_clock_output_control i_dut (.clock, .rst_b, .soft_reset, .mgmt_addr,
    .mgmt_write_data, .mgmt_write, .mgmt_read, .mgmt_read_data, .recovered_clock_25,
    .recovered_clock_125, .recovered_clock_31p25, .link_up, .link_stable, .link_speed,
    .link_master, .eee_active, .lpi_receiving, .clock_squelch_in, .recovered_clock_output);
  timing_sink_model i_sink (.clock, .rst_b, .recovered_clock_output, .squelch_request,
    .clock_squelch_in, .edge_count);
  // Clock generation.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Recovered clock stimulus and the run-time ceiling.
  always @(negedge clock) begin
    cycles <= cycles + 1;
    recovered_clock_125   <= cycles[0];
    recovered_clock_25    <= cycles[1];
    recovered_clock_31p25 <= cycles[2];
    if (cycles > 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(logic [4:0] a, logic [15:0] d);
    mgmt_addr = a;
    mgmt_write_data = d;
    mgmt_write = 1'b1;
    @(negedge clock);
    mgmt_write = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rd(logic [4:0] a, logic [15:0] exp, string name);
    mgmt_addr = a;
    mgmt_read = 1'b1;
    @(negedge clock);
    mgmt_read = 1'b0;
    check(name, mgmt_read_data, exp);
    @(negedge clock);
  endtask : rd
  // Sets link state {up,stable,speed,master,eee,lpi,pin}, writes control, watches edges.
  task automatic run(logic [15:0] ctl, logic [7:0] lk, logic exp);
    {link_up, link_stable} = lk[7:6];
    link_speed = link_speed_type'(lk[5:4]);
    {link_master, eee_active, lpi_receiving, squelch_request} = lk[3:0];
    wr(5'h17, ctl);
    start = edge_count;
    repeat (40) @(negedge clock);
    check("clock activity", {15'h0000, edge_count != start}, {15'h0000, exp});
    if (exp === 1'b0) check("clock held low", {15'h0000, recovered_clock_output}, 16'h0000);
  endtask : run
  // Main sequence.
  initial begin
    {rst_b, soft_reset, mgmt_write, mgmt_read, squelch_request, link_up} = 6'h00;
    {link_stable, link_master, eee_active, lpi_receiving} = 4'h0;
    {mgmt_addr, mgmt_write_data} = '0;
    link_speed = speed_10;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    rd(5'h17, 16'h0000, "main page control");
    wr(5'h1f, 16'h0010);
    rd(5'h17, 16'h0000, "control reset");
    rd(5'h18, 16'h0000, "unmapped");
    wr(5'h17, 16'hffff);
    rd(5'h17, 16'h8737, "control mask");
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    rd(5'h1f, 16'h0000, "page after soft reset");
    wr(5'h1f, 16'h0010);
    rd(5'h17, 16'h8737, "control kept");
    run(16'h0031, 8'hc0, 1'b0);
    run(16'h8032, 8'hc0, 1'b0);
    run(16'h8331, 8'hc0, 1'b0);
    run(16'h8131, 8'hc0, 1'b1);
    run(16'h8231, 8'hc0, 1'b1);
    run(16'h8031, 8'h00, 1'b1);
    run(16'h8021, 8'h00, 1'b0);
    run(16'h8021, 8'h80, 1'b1);
    run(16'h8001, 8'hc0, 1'b0);
    run(16'h8001, 8'he8, 1'b0);
    run(16'h8001, 8'he0, 1'b1);
    run(16'h8001, 8'hd4, 1'b0);
    run(16'h8011, 8'hc0, 1'b1);
    run(16'h8011, 8'hd6, 1'b1);
    run(16'h8011, 8'h80, 1'b0);
    run(16'h8011, 8'hd4, 1'b0);
    run(16'h8011, 8'he8, 1'b1);
    run(16'h8001, 8'hd6, 1'b0);
    run(16'h8001, 8'he4, 1'b0);
    run(16'h8031, 8'h01, 1'b0);
    wr(5'h1f, 16'h0000);
    end_sim();
  end
endmodule : recovered_clock_output_control_bench
